// file: hw/tcrc_pkg.sv
// package: widths, counts, timing constants for the tape check character sequencer
package tcrc_pkg;
	// ********************************************************
	// widths and counts
	// ********************************************************
	localparam int TCRC_CHAR_W = 9;
	localparam int TCRC_FIFO_DEPTH = 8;
	localparam logic [TCRC_CHAR_W-1:0] TCRC_CHAR_ZERO = 9'h000;
	// bits 2 and 4 of the ring are read out uninverted (bit order P,0..7 -> index 0..8)
	localparam logic [TCRC_CHAR_W-1:0] TCRC_OUT_INVERT = 9'h1D7;
	// stages 2..5 take stage 7 feedback (indices 3..6)
	localparam logic [TCRC_CHAR_W-1:0] TCRC_FB_MASK = 9'h078;
	localparam int TCRC_IDX_B7 = 8;
	// ********************************************************
	// gap counter counts
	// ********************************************************
	localparam logic [1:0] TCRC_CNT_T0 = 2'h0;
	localparam logic [1:0] TCRC_CNT_T1 = 2'h1;
	localparam logic [1:0] TCRC_CNT_T3 = 2'h3;
	localparam logic [2:0] TCRC_LCC_HOLD = 3'h4;
	// ********************************************************
	// timing
	// ********************************************************
	localparam int TCRC_CLK_NS = 100;
	localparam int TCRC_GAP_PULSE_US = 30;
	localparam int TCRC_GAP_PULSE_CYC = (TCRC_GAP_PULSE_US * 1000) / TCRC_CLK_NS;
	localparam logic [8:0] TCRC_GAP_PULSE_CNT = 9'(TCRC_GAP_PULSE_CYC);
endpackage

// file: hw/tcrc_fifo.sv
// file: parameterised valid/ready fifo for data characters
`timescale 1ns/1ns
`default_nettype none
module tcrc_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// honest full/empty from occupancy
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// storage write
	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			if (push && !pop) begin
				count <= count + 1'b1;
			end else if (pop && !push) begin
				count <= count - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// file: hw/tcrc_seq.sv
// file: check register, gap sequencer and AXI4-Lite status/control slave
// Function
// - each write step outside a gap reloads the check register from data and state
// - nine-stage ring P,0..7; stage gets data xor previous; stages 2-5 add bit 7
// - register clocks on the step write strobe from the write-step command; here it clocks when the character leaves the fifo (take_step)
// - gap start zeroes data out, blocks amp clock, sets the primer flag
// - gap clocks come from step-position pulses only in gaps, first 30 us
// - two-stage gap counter; once back at zero it stays until primed again
// - first gap clock after priming clears the primer flag
// - second gap clock shifts the check register once with zero data
// - fourth gap clock, unless suppressed, outputs check char and pulses amp clock
// - check char is the register inverted except bits 2 and 4
// - gap clock at count zero clears the check register; repeats allowed
// - no clear pulse while the primer flag is set
// - clear pulse sets suppress flag, which blocks the fourth-count output
// - suppress flag cleared only by the first write step after a gap
// - longitudinal inhibit held low during the first four gap clocks
// - file mark captured in a buffer; next gap clock at count zero primes
// - file mark buffer cleared by the unsuppressed-before-gate fourth count
// - end-of-file gap runs a second pass with suppressed check char
//
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module tcrc_seq
	import tcrc_pkg::*;
#(
	parameter int CHAR_W = TCRC_CHAR_W
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// data source
	input wire logic step_write_strobe,
	input wire logic [tcrc_pkg::TCRC_CHAR_W-1:0] data_in,
	input wire logic gap_active,
	input wire logic file_mark,
	input wire logic step_position,
	output logic source_ready,
	// write amplifiers
	output logic [tcrc_pkg::TCRC_CHAR_W-1:0] amp_data,
	output logic amp_write_clock,
	output logic lcc_enable,
	// axi4-lite slave
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready
);
	import tcrc_pkg::*;

	// ********************************************************
	// register map
	// ********************************************************
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_STAT = 4'h4;
	localparam logic [3:0] ADDR_CHK = 4'h8;
	localparam logic [1:0] RESP_OK = 2'h0;
	localparam logic [1:0] RESP_DEC = 2'h3;

	typedef enum logic [1:0] {
		TCRC_IDLE = 2'b00,
		TCRC_PULSE = 2'b01,
		TCRC_HOLD = 2'b10
	} tcrc_gclk_t;

	logic [CHAR_W-1:0] check_register;
	logic [1:0] gap_count;
	logic primer;
	logic suppress;
	logic fm_buf;
	logic gap_q;
	logic [2:0] lcc_count;
	logic soft_clear;
	logic step_hold;
	tcrc_gclk_t gclk_state;
	logic [8:0] gclk_timer;
	logic gap_clk;
	logic fifo_valid;
	logic [CHAR_W-1:0] fifo_data;
	logic fifo_in_ready;
	logic take_step;
	logic t1_shift;
	logic t3_raw;
	logic t3_gated;
	logic t0_clear;
	logic fm_prime;
	logic [CHAR_W-1:0] next_check;
	logic [CHAR_W-1:0] shift_zero;
	logic [CHAR_W-1:0] ring_prev;
	logic [CHAR_W-1:0] ring_prev_z;

	// ********************************************************
	// data buffering
	// ********************************************************
	// characters queue here so the source can run ahead of the amp
	tcrc_fifo #(.WIDTH(CHAR_W), .DEPTH(TCRC_FIFO_DEPTH)) u_fifo (
		.clock(clock),
		.rstn(rstn),
		.in_valid(step_write_strobe && !gap_active),
		.in_ready(fifo_in_ready),
		.in_data(data_in),
		.out_valid(fifo_valid),
		.out_ready(take_step),
		.out_data(fifo_data)
	);

	// ready registered; source must hold strobes while low
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			source_ready <= 1'b0;
		end else begin
			source_ready <= fifo_in_ready && !step_hold;
		end
	end

	// drain one character per cycle unless software holds stepping or a gap is active
	assign take_step = fifo_valid && !step_hold && !gap_q;

	// ********************************************************
	// ring next-state
	// ********************************************************
	// ring order: index 0 = P, index k+1 = bit k; bit 7 wraps to P
	assign ring_prev = {check_register[CHAR_W-2:0], check_register[CHAR_W-1]};
	assign ring_prev_z = ring_prev ^ (TCRC_FB_MASK & {CHAR_W{check_register[TCRC_IDX_B7]}});
	always_comb begin
		next_check = '0;
		shift_zero = '0;
		for (int i = 0; i < CHAR_W; i++) begin
			next_check[i] = fifo_data[i] ^ ring_prev_z[i];
			shift_zero[i] = ring_prev_z[i];
		end
	end

	// ********************************************************
	// gap clock generation
	// ********************************************************
	// one gap clock per position pulse, only inside a gap; the timed window
	// mirrors the first part of the shutter pulse without using its tail
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gclk_state <= TCRC_IDLE;
			gclk_timer <= '0;
			gap_clk <= 1'b0;
		end else begin
			gap_clk <= 1'b0;
			unique case (gclk_state)
				TCRC_IDLE: begin
					if (step_position && gap_q) begin
						gap_clk <= 1'b1;
						gclk_timer <= TCRC_GAP_PULSE_CNT;
						gclk_state <= TCRC_PULSE;
					end
				end
				TCRC_PULSE: begin
					if (gclk_timer <= 9'h001) begin
						gclk_state <= TCRC_HOLD;
					end else begin
						gclk_timer <= gclk_timer - 9'h001;
					end
				end
				TCRC_HOLD: begin
					if (!step_position) begin
						gclk_state <= TCRC_IDLE;
					end
				end
				default: begin
					gclk_state <= TCRC_IDLE;
				end
			endcase
		end
	end

	// ********************************************************
	// gap count decode
	// ********************************************************
	assign t1_shift = gap_clk && (gap_count == TCRC_CNT_T1);
	assign t3_raw = gap_clk && (gap_count == TCRC_CNT_T3);
	assign t3_gated = t3_raw && !suppress;
	assign t0_clear = gap_clk && (gap_count == TCRC_CNT_T0) && !primer;
	assign fm_prime = gap_clk && fm_buf && (gap_count == TCRC_CNT_T0) && !primer;

	// ********************************************************
	// check register
	// ********************************************************
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			check_register <= '0;
		end else if (t0_clear || soft_clear) begin
			check_register <= '0;
		end else if (t1_shift) begin
			check_register <= shift_zero;
		end else if (take_step) begin
			check_register <= next_check;
		end
	end

	// gap level edge tracking
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gap_q <= 1'b0;
		end else begin
			gap_q <= gap_active;
		end
	end

	// ********************************************************
	// primer, counter, flags
	// ********************************************************
	// gap entry sets primer; the first gap clock always wins and clears it
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			primer <= 1'b0;
		end else if (gap_clk && primer) begin
			primer <= 1'b0;
		end else if ((gap_active && !gap_q) || fm_prime) begin
			primer <= 1'b1;
		end
	end

	// counter only leaves zero when primed
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			gap_count <= TCRC_CNT_T0;
		end else if (gap_clk && (primer || gap_count != TCRC_CNT_T0)) begin
			gap_count <= gap_count + 2'h1;
		end
	end

	// suppress: clear pulse sets, first write step clears; set wins
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			suppress <= 1'b0;
		end else if (t0_clear) begin
			suppress <= 1'b1;
		end else if (take_step) begin
			suppress <= 1'b0;
		end
	end

	// file mark buffer: capture wins over the fourth-count clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			fm_buf <= 1'b0;
		end else if (file_mark) begin
			fm_buf <= 1'b1;
		end else if (t3_raw) begin
			fm_buf <= 1'b0;
		end
	end

	// longitudinal inhibit: low for the first four gap clocks of a pass
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			lcc_count <= TCRC_LCC_HOLD;
		end else if (gap_clk && primer) begin
			lcc_count <= 3'h1;
		end else if (gap_clk && lcc_count < TCRC_LCC_HOLD) begin
			lcc_count <= lcc_count + 3'h1;
		end
	end

	// ********************************************************
	// amplifier outputs
	// ********************************************************
	// data passes through outside gaps; gaps force zero except the readout
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			amp_data <= '0;
			amp_write_clock <= 1'b0;
			lcc_enable <= 1'b1;
		end else begin
			lcc_enable <= !((gap_clk && primer) || lcc_count < TCRC_LCC_HOLD);
			if (t3_gated) begin
				amp_data <= check_register ^ TCRC_OUT_INVERT;
				amp_write_clock <= 1'b1;
			end else if (take_step) begin
				amp_data <= fifo_data;
				amp_write_clock <= 1'b1;
			end else begin
				amp_data <= gap_q ? TCRC_CHAR_ZERO : amp_data;
				amp_write_clock <= 1'b0;
			end
		end
	end

	// ********************************************************
	// axi4-lite slave
	// ********************************************************
	// write: ctrl bit0 holds stepping, bit1 self-clearing register clear
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			s_bvalid <= 1'b0;
			s_bresp <= RESP_OK;
			step_hold <= 1'b0;
			soft_clear <= 1'b0;
		end else begin
			soft_clear <= 1'b0;
			s_awready <= 1'b0;
			s_wready <= 1'b0;
			if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end else if (!s_bvalid && s_awvalid && s_wvalid && !s_awready) begin
				s_awready <= 1'b1;
				s_wready <= 1'b1;
				s_bvalid <= 1'b1;
				s_bresp <= (s_awaddr == ADDR_CTRL) ? RESP_OK : RESP_DEC;
				if (s_awaddr == ADDR_CTRL && s_wstrb[0]) begin
					step_hold <= s_wdata[0];
					soft_clear <= s_wdata[1];
				end
			end
		end
	end

	// read: status shows counter, flags; check shows the ring
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			s_arready <= 1'b0;
			s_rvalid <= 1'b0;
			s_rdata <= 32'h00000000;
			s_rresp <= RESP_OK;
		end else begin
			s_arready <= 1'b0;
			if (s_rvalid && s_rready) begin
				s_rvalid <= 1'b0;
			end else if (!s_rvalid && s_arvalid && !s_arready) begin
				s_arready <= 1'b1;
				s_rvalid <= 1'b1;
				s_rresp <= RESP_OK;
				unique case (s_araddr)
					ADDR_CTRL: s_rdata <= {31'h0, step_hold};
					ADDR_STAT: s_rdata <= {26'h0, fm_buf, suppress, primer, gap_q, gap_count};
					ADDR_CHK: s_rdata <= {23'h0, check_register};
					default: begin
						s_rdata <= 32'h00000000;
						s_rresp <= RESP_DEC;
					end
				endcase
			end
		end
	end

	// ********************************************************
	// checks
	// ********************************************************
	a_primer_clear: assert property (@(posedge clock) disable iff (!rstn)
		(gap_clk && primer) |=> !primer || fm_prime)
		else $error("primer not cleared by gap clock");
	a_count_hold: assert property (@(posedge clock) disable iff (!rstn)
		(gap_count == TCRC_CNT_T0 && !primer) |=> gap_count == TCRC_CNT_T0)
		else $error("counter left zero unprimed");
	a_clear_ring: assert property (@(posedge clock) disable iff (!rstn)
		t0_clear |=> check_register == '0)
		else $error("ring not cleared");
	a_no_clear_primed: assert property (@(posedge clock) disable iff (!rstn)
		(gap_clk && primer) |-> !t0_clear)
		else $error("clear while primed");
	a_suppress_blocks: assert property (@(posedge clock) disable iff (!rstn)
		(t3_raw && suppress) |=> !amp_write_clock)
		else $error("check char written while suppressed");
	a_check_out: assert property (@(posedge clock) disable iff (!rstn)
		t3_gated |=> amp_data == ($past(check_register) ^ TCRC_OUT_INVERT) && amp_write_clock)
		else $error("check char value wrong");
	a_gap_zero: assert property (@(posedge clock) disable iff (!rstn)
		(gap_q && !t3_gated && !take_step) |=> amp_data == '0 && !amp_write_clock)
		else $error("data not forced in gap");
	a_gclk_gap: assert property (@(posedge clock) disable iff (!rstn)
		gap_clk |-> $past(gap_q))
		else $error("gap clock outside gap");
	a_lcc_low: assert property (@(posedge clock) disable iff (!rstn)
		(gap_clk && primer) |=> !lcc_enable)
		else $error("lcc not inhibited");
	a_fm_clear: assert property (@(posedge clock) disable iff (!rstn)
		(t3_raw && !file_mark) |=> !fm_buf)
		else $error("file mark buffer not cleared");
endmodule
`default_nettype wire

// file: verification/tcrc_src_model.sv
// partner model: data source issuing write steps, gaps, file marks and step-position pulses
`timescale 1ns/1ns
`default_nettype none
module tcrc_src_model (
	// clock
	input wire logic clock,
	// flow control from the block
	input wire logic source_ready,
	// commands to the block
	output logic step_write_strobe,
	output logic [8:0] data_in,
	output logic gap_active,
	output logic file_mark,
	output logic step_position
);
	// idle levels at time zero
	initial begin
		step_write_strobe = 1'b0;
		data_in = 9'h000;
		gap_active = 1'b0;
		file_mark = 1'b0;
		step_position = 1'b0;
	end
	// one write step; the data line has no pull, so it shows the inverse once released
	task automatic write_char(input logic [8:0] d);
		do @(posedge clock); while (source_ready !== 1'b1);
		step_write_strobe <= 1'b1;
		data_in <= d;
		@(posedge clock);
		step_write_strobe <= 1'b0;
		data_in <= ~d;
	endtask
	// gap level, with a few cycles to settle
	task automatic set_gap(input logic g);
		@(posedge clock);
		gap_active <= g;
		repeat (3) @(posedge clock);
	endtask
	// file mark as a single-cycle strobe
	task automatic mark();
		@(posedge clock);
		file_mark <= 1'b1;
		@(posedge clock);
		file_mark <= 1'b0;
	endtask
	// shutter pulse; the long idle tail keeps clear of the 300-cycle gap clock window
	task automatic step_pulse();
		@(posedge clock);
		step_position <= 1'b1;
		repeat (5) @(posedge clock);
		step_position <= 1'b0;
		repeat (305) @(posedge clock);
	endtask
endmodule
`default_nettype wire

// file: verification/tape_crc_check_char_sequencer_tb_top.sv
// testbench: check character sequencer with source model, register bus and fifo
`timescale 1ns/1ns
`default_nettype none
module tape_crc_check_char_sequencer_tb_top;
	import tcrc_pkg::*;
	// ********************************************************
	// signals and instances
	// ********************************************************
	logic clock, rstn;
	logic step_write_strobe, gap_active, file_mark, step_position, source_ready;
	logic [8:0] data_in, amp_data;
	logic amp_write_clock, lcc_enable;
	logic [3:0] s_awaddr, s_araddr, s_wstrb;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic [31:0] s_wdata, s_rdata, v;
	logic [1:0] s_bresp, s_rresp, rr;
	logic [8:0] amp_q[$];
	int err_count, cmp_count;
	tcrc_seq dut_u (.clock, .rstn, .step_write_strobe, .data_in, .gap_active, .file_mark, .step_position,
		.source_ready, .amp_data, .amp_write_clock, .lcc_enable, .s_awaddr, .s_awvalid, .s_awready,
		.s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr,
		.s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid, .s_rready);
	tcrc_src_model src_u (.clock, .source_ready, .step_write_strobe, .data_in, .gap_active, .file_mark,
		.step_position);
	// clock at 100 ns
	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end
	// record every amplifier write so scenarios can count and compare them
	always @(posedge clock) begin
		if (amp_write_clock === 1'b1) begin
			amp_q.push_back(amp_data);
		end
	end
	// ********************************************************
	// helpers
	// ********************************************************
	// reference ring step, index 0 is P; bits 2..5 sit at indices 3..6
	function automatic logic [8:0] ring_next(input logic [8:0] r, input logic [8:0] d);
		logic [8:0] n;
		n = d ^ {r[7:0], r[8]};
		n[6:3] = n[6:3] ^ {4{r[8]}};
		return n;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		@(posedge clock);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wstrb <= s;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_awready === 1'b1) s_awvalid <= 1'b0;
			if (s_wready === 1'b1) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clock);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_arready === 1'b1) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask
	task automatic end_of_test();
		if (err_count == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// ********************************************************
	// scenarios
	// ********************************************************
	// reset state, unmapped address, step hold
	task automatic t_regs();
		chk(lcc_enable, 1'b1);
		rd(4'h4, v, rr);
		chk(v, 32'h0);
		rd(4'h8, v, rr);
		chk(v, 32'h0);
		rd(4'hC, v, rr);
		chk(rr, 2'h3);
		wr(4'hC, 32'h1, 4'hF, rr);
		chk(rr, 2'h3);
		// a write with no byte strobes must not land
		wr(4'h0, 32'h1, 4'h0, rr);
		repeat (3) @(posedge clock);
		chk(source_ready, 1'b1);
		wr(4'h0, 32'h1, 4'hF, rr);
		repeat (3) @(posedge clock);
		chk(source_ready, 1'b0);
		wr(4'h0, 32'h0, 4'hF, rr);
		repeat (3) @(posedge clock);
		chk(source_ready, 1'b1);
	endtask
	// a record of three characters, then its gap pass
	task automatic t_record();
		logic [8:0] recd [3];
		logic [8:0] r;
		recd = '{9'h1A5, 9'h0F3, 9'h100};
		r = 9'h000;
		foreach (recd[i]) begin
			src_u.write_char(recd[i]);
			r = ring_next(r, recd[i]);
		end
		repeat (6) @(posedge clock);
		foreach (recd[i]) chk(amp_q[i], recd[i]);
		rd(4'h8, v, rr);
		chk(v, r);
		src_u.set_gap(1'b1);
		chk(amp_data, 9'h000);
		src_u.step_pulse();
		rd(4'h8, v, rr);
		chk(v, r);
		chk(lcc_enable, 1'b0);
		src_u.step_pulse();
		rd(4'h8, v, rr);
		chk(v, ring_next(r, 9'h000));
		repeat (2) src_u.step_pulse();
		chk(amp_q.size(), 4);
		chk(amp_q[3], ring_next(r, 9'h000) ^ 9'h1D7);
		repeat (2) src_u.step_pulse();
		chk(lcc_enable, 1'b1);
		rd(4'h8, v, rr);
		chk(v, 32'h0);
		rd(4'h4, v, rr);
		chk(v[1:0], 2'h0);
		chk(v[4], 1'b1);
		src_u.set_gap(1'b0);
	endtask
	// a second gap with no data writes nothing
	task automatic t_empty_gap();
		src_u.set_gap(1'b1);
		repeat (5) src_u.step_pulse();
		src_u.set_gap(1'b0);
		chk(amp_q.size(), 4);
	endtask
	// new record after the clear; shutter pulses outside a gap do nothing
	task automatic t_restart();
		src_u.write_char(9'h0C3);
		repeat (4) @(posedge clock);
		rd(4'h4, v, rr);
		chk(v[4], 1'b0);
		rd(4'h8, v, rr);
		chk(v, 32'h0C3);
		src_u.step_pulse();
		rd(4'h8, v, rr);
		chk(v, 32'h0C3);
		rd(4'h4, v, rr);
		chk(v[1:0], 2'h0);
		chk(amp_q.size(), 5);
	endtask
	// end-of-file gap: normal pass, then a suppressed pass after the mark
	task automatic t_file_mark();
		src_u.set_gap(1'b1);
		repeat (5) src_u.step_pulse();
		chk(amp_q[5], ring_next(9'h0C3, 9'h000) ^ 9'h1D7);
		src_u.mark();
		rd(4'h4, v, rr);
		chk(v[5], 1'b1);
		repeat (2) src_u.step_pulse();
		chk(lcc_enable, 1'b0);
		repeat (4) src_u.step_pulse();
		chk(amp_q.size(), 6);
		rd(4'h4, v, rr);
		chk(v[5], 1'b0);
		src_u.set_gap(1'b0);
	endtask
	// a burst of a queue's worth of characters passes the block in order, then a soft clear
	task automatic t_fifo();
		logic [8:0] r;
		int base;
		r = 9'h000;
		base = amp_q.size();
		for (int i = 0; i < TCRC_FIFO_DEPTH; i++) begin
			src_u.write_char(9'h100 + 9'(i));
			r = ring_next(r, 9'h100 + 9'(i));
		end
		repeat (4) @(posedge clock);
		chk(amp_q.size(), base + TCRC_FIFO_DEPTH);
		for (int i = 0; i < TCRC_FIFO_DEPTH; i++) chk(amp_q[base + i], 9'h100 + 9'(i));
		rd(4'h8, v, rr);
		chk(v, r);
		wr(4'h0, 32'h2, 4'hF, rr);
		rd(4'h8, v, rr);
		chk(v, 32'h0);
	endtask
	// ********************************************************
	// main sequence and watchdog
	// ********************************************************
	initial begin
		err_count = 0;
		cmp_count = 0;
		rstn = 1'b0;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
		{s_awaddr, s_araddr, s_wstrb} = 12'h000;
		s_wdata = 32'h0;
		repeat (4) @(posedge clock);
		rstn <= 1'b1;
		repeat (2) @(posedge clock);
		t_regs();
		t_record();
		t_empty_gap();
		t_restart();
		t_file_mark();
		t_fifo();
		end_of_test();
	end
	// about five times the expected run; a hang counts as a mismatch
	initial begin
		repeat (40000) @(posedge clock);
		err_count++;
		end_of_test();
	end
endmodule
`default_nettype wire
